// File: cpu_space_bus.sv
// What this block does
// RL1: space select lines pick one of eight spaces; space 7 is cpu space.
// RL2: space select lines only carry meaning while address strobe is low.
// RL3: address bits 19:16 carry cpu space type: 0 breakpoint_request_n, 3 stop, F int ack.
// RL4: software breakpoint reads type 0, number on bits 4:2, bit 1 low.
// RL5: outside logic answers software breakpoint with bus error or word plus ack.
// RL6: acked software breakpoint word goes to the pipeline, two reads on 8-bit port.
// RL7: bus error on software breakpoint starts illegal instruction exception.
// RL8: hardware breakpoint request reads address 1E: type 0, number 7, bit 1 high.
// RL9: hardware breakpoint answered by bus error starts breakpoint exception.
// RL10: hardware breakpoint answered by size ack is dropped.
// RL11: breakpoint on prefetch tags the instruction; a flush cancels it.
// RL12: breakpoint on operand fetch fires at the end of that instruction.
// RL13: low power stop writes the priority mask to address 3FFFE.
// RL14: stop write puts mask in low data bits, bits 15 to 3 zero.
// RL15: stop broadcast cycle is shown on the external bus when owned.
// RL16: stop broadcast ends by own internal ack with fast write timing.
// RL17: low power mode ends on interrupt above stored mask or on reset; code also wakes on level 7 when the mask is 7.
// RL18: outside devices end cycles by size ack or autovector.
// RL19: bus monitor raises internal bus error, giving bus error exception.
// RL20: normal end is size ack with bus error and halt both negated.
// RL21: halt end is halt with or before size ack, bus error negated.
// RL22: after halt end, no new cycle starts until halt is negated.
// RL23: bus monitor period is settable, never off, at most 64 cycles.
// RL24: bus error without halt ends the cycle and takes bus error exception.
// RL25: bus error with halt ends the cycle and reruns it after halt clears.
// RL26: space select lines hold 111 for all of every special cycle.
`timescale 1ns/10ps
`default_nettype none
module cpu_space_bus (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // core requests
  input wire logic sw_breakpoint_request_n_req_i,
  input wire logic [2:0] sw_breakpoint_request_n_num_i,
  input wire logic low_power_stop_instruction_i,
  input wire logic [2:0] interrupt_priority_mask_i,
  input wire logic prefetch_active_i,
  input wire logic instr_end_i,
  input wire logic pipe_flush_i,
  input wire logic port_8bit_i,
  input wire logic [5:0] bus_mon_limit_i,
  input wire logic bus_granted_i,
  input wire logic [2:0] int_level_i,
  // external pins
  input wire logic breakpoint_request_n_i,
  input wire logic [1:0] size_acknowledge_n_i,
  input wire logic autovector_ack_n_i,
  input wire logic bus_error_n_i,
  input wire logic halt_n_i,
  input wire logic [15:0] data_in_i,
  output logic [2:0] space_select_lines_o,
  output logic [23:0] addr_o,
  output logic address_strobe_n_o,
  output logic data_strobe_n_o,
  output logic read_write_o,
  output logic [15:0] data_out_o,
  output logic data_oe_o,
  // core results
  output logic instr_valid_o,
  output logic [15:0] instr_word_o,
  output logic illegal_exc_o,
  output logic hw_breakpoint_request_n_exc_o,
  output logic bus_err_exc_o,
  output logic low_power_o,
  output logic [2:0] stored_mask_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b011,
    ST_HALT = 3'b100,
    ST_STOP = 3'b101
  } state_type;

  typedef enum logic [1:0] {
    CYC_SW = 2'b00,
    CYC_HW = 2'b01,
    CYC_LP = 2'b10
  } cycle_type;

  function automatic logic [23:0] cpu_addr(input logic [3:0] kind, input logic [2:0] num,
                                          input logic hw);
    logic [23:0] a;
    a = cpu_space_pkg::ADDR_RESET;
    a[cpu_space_pkg::TYPE_LSB +: 4] = kind;
    a[cpu_space_pkg::BREAKPOINT_REQUEST_N_NUM_LSB +: 3] = num;
    a[cpu_space_pkg::BREAKPOINT_REQUEST_N_HW_BIT] = hw;
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] pins_s;
  logic breakpoint_request_n_n_s;
  logic [1:0] dsack_n_s;
  logic autovector_ack_n_n_s;
  logic bus_error_n_n_s;
  logic halt_n_s;

  sync3 #(.WIDTH(6), .INIT(6'h3F)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i({breakpoint_request_n_i, size_acknowledge_n_i, autovector_ack_n_i,
              bus_error_n_i, halt_n_i}),
    .sync_o(pins_s)
  );
  assign breakpoint_request_n_n_s = pins_s[5];
  assign dsack_n_s = pins_s[4:3];
  assign autovector_ack_n_n_s = pins_s[2];
  assign bus_error_n_n_s = pins_s[1];
  assign halt_n_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // state
  state_type state_q, state_d;
  cycle_type cyc_q, cyc_d;
  logic [5:0] mon_q;
  logic second_q;
  logic [7:0] lo_byte_q;
  logic halt_seen_q;
  logic retry_q;
  logic breakpoint_request_n_pend_q;
  logic tag_q;
  logic op_breakpoint_request_n_q;
  logic breakpoint_request_n_prev_n_q;
  logic [2:0] sw_num_q;
  logic [2:0] mask_q;

  logic acked, bus_error_n_now, mon_expired, breakpoint_request_n_edge, lp_done, term_clear;
  // a late ack or bus error must not end the next cycle early
  assign term_clear = (dsack_n_s == 2'b11) && autovector_ack_n_n_s && bus_error_n_n_s;
  logic start_sw, start_hw, start_lp, start_any, wake;
  // lp stop cycle is acked internally: fast write timing
  assign acked = (cyc_q == CYC_LP) || (dsack_n_s != 2'b11) || !autovector_ack_n_n_s; // RL16 RL18
  assign mon_expired = (mon_q == bus_mon_limit_i) || (mon_q == cpu_space_pkg::BUS_MON_RESET); // RL23
  assign bus_error_n_now = !bus_error_n_n_s || mon_expired; // RL19
  assign breakpoint_request_n_edge = breakpoint_request_n_prev_n_q && !breakpoint_request_n_n_s;
  assign start_hw = breakpoint_request_n_pend_q;
  assign start_sw = !breakpoint_request_n_pend_q && sw_breakpoint_request_n_req_i;
  assign start_lp = !breakpoint_request_n_pend_q && !sw_breakpoint_request_n_req_i && low_power_stop_instruction_i
                    && bus_granted_i; // RL15
  assign start_any = start_hw || start_sw || start_lp;
  assign wake = (int_level_i > mask_q) || (int_level_i == 3'h7); // RL17
  assign lp_done = (state_q == ST_WAIT) && (cyc_q == CYC_LP);

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    case (state_q)
      ST_IDLE: begin
        if (halt_n_s && start_any) begin // RL22
          state_d = ST_ADDR;
          cyc_d = start_hw ? CYC_HW : (start_sw ? CYC_SW : CYC_LP);
        end
      end
      ST_ADDR: state_d = ST_WAIT;
      ST_WAIT: begin
        if (bus_error_n_now || acked) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!term_clear) begin
          state_d = ST_DONE;
        end else if (retry_q || halt_seen_q) begin
          state_d = ST_HALT;
        end else if (cyc_q == CYC_LP) begin
          state_d = ST_STOP;
        end else if (cyc_q == CYC_SW && port_8bit_i && second_q) begin
          state_d = ST_ADDR; // RL6
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_HALT: begin
        if (halt_n_s && term_clear) begin
          state_d = retry_q ? ST_ADDR : ST_IDLE; // RL25 RL22
        end
      end
      ST_STOP: begin
        if (wake) begin
          state_d = ST_IDLE; // RL17
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  logic in_cycle;
  assign in_cycle = (state_q == ST_ADDR) || (state_q == ST_WAIT);
  logic [23:0] addr_d;
  logic [2:0] num_d;
  // the address goes out with the strobe, so it follows the cycle being started
  assign num_d = (state_q == ST_IDLE) ? sw_breakpoint_request_n_num_i : sw_num_q;
  assign addr_d = (cyc_d == CYC_LP) ? cpu_space_pkg::LP_STOP_ADDR // RL13
                : (cyc_d == CYC_HW) ? cpu_space_pkg::HW_BREAKPOINT_REQUEST_N_ADDR // RL8
                : (cpu_addr(cpu_space_pkg::TYPE_BREAKPOINT_REQUEST_N_ACK, num_d, 1'b0)
                   | {23'h000000, second_q}); // RL3 RL4
  logic end_ok, end_bus_error_n;
  // a halt end still completes the cycle and takes its data
  assign end_ok = (state_q == ST_WAIT) && !bus_error_n_now && acked; // RL20 RL21 RL22
  assign end_bus_error_n = (state_q == ST_WAIT) && bus_error_n_now && halt_n_s && !retry_q; // RL24

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      cyc_q <= CYC_SW;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
    end
  end

  // bus monitor and termination capture
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mon_q <= 6'h00;
      halt_seen_q <= 1'b0;
      retry_q <= 1'b0;
    end else begin
      mon_q <= (state_q == ST_WAIT) ? mon_q + 6'h01 : 6'h00; // RL23
      if (state_q == ST_WAIT && !halt_n_s && !bus_error_n_now) begin
        halt_seen_q <= 1'b1; // RL21
      end else if (state_q == ST_IDLE) begin
        halt_seen_q <= 1'b0;
      end
      if (state_q == ST_WAIT && !halt_n_s && bus_error_n_now) begin
        retry_q <= 1'b1; // RL25
      end else if (state_q == ST_HALT && halt_n_s && term_clear) begin
        retry_q <= 1'b0;
      end
    end
  end

  // breakpoint request latch and instruction tagging
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      breakpoint_request_n_prev_n_q <= 1'b1;
      breakpoint_request_n_pend_q <= 1'b0;
      tag_q <= 1'b0;
      op_breakpoint_request_n_q <= 1'b0;
      sw_num_q <= 3'h0;
    end else begin
      breakpoint_request_n_prev_n_q <= breakpoint_request_n_n_s;
      if (breakpoint_request_n_edge && prefetch_active_i) begin
        tag_q <= 1'b1; // RL11
      end else if (pipe_flush_i) begin
        tag_q <= 1'b0; // RL11
      end else if (instr_end_i) begin
        tag_q <= 1'b0;
      end
      if (breakpoint_request_n_edge && !prefetch_active_i) begin
        op_breakpoint_request_n_q <= 1'b1; // RL12
      end else if (instr_end_i) begin
        op_breakpoint_request_n_q <= 1'b0;
      end
      if (instr_end_i && ((tag_q && !pipe_flush_i) || op_breakpoint_request_n_q)) begin
        breakpoint_request_n_pend_q <= 1'b1; // RL11 RL12
      end else if (state_q == ST_IDLE && start_hw && halt_n_s) begin
        breakpoint_request_n_pend_q <= 1'b0;
      end
      if (state_q == ST_IDLE && start_sw) begin
        sw_num_q <= sw_breakpoint_request_n_num_i;
      end
    end
  end

  // external bus pins
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      space_select_lines_o <= cpu_space_pkg::SPACE_DEFAULT;
      addr_o <= cpu_space_pkg::ADDR_RESET;
      address_strobe_n_o <= 1'b1;
      data_strobe_n_o <= 1'b1;
      read_write_o <= 1'b1;
      data_out_o <= cpu_space_pkg::DATA_RESET;
      data_oe_o <= 1'b0;
    end else begin
      // cpu space code stays on the lines through the whole cycle
      space_select_lines_o <= in_cycle || state_d == ST_ADDR ? cpu_space_pkg::SPACE_CPU
                              : cpu_space_pkg::SPACE_DEFAULT; // RL1 RL26
      addr_o <= (state_d == ST_ADDR || in_cycle) ? addr_d : addr_o;
      address_strobe_n_o <= !(state_d == ST_ADDR || state_d == ST_WAIT); // RL2
      data_strobe_n_o <= !(state_d == ST_WAIT && cyc_d != CYC_LP);
      read_write_o <= !((state_d == ST_ADDR || state_d == ST_WAIT) && cyc_d == CYC_LP);
      data_out_o <= {13'h0000, interrupt_priority_mask_i}; // RL14
      data_oe_o <= (state_d == ST_ADDR || state_d == ST_WAIT) && cyc_d == CYC_LP;
    end
  end

  // results back to the core
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      instr_valid_o <= 1'b0;
      instr_word_o <= cpu_space_pkg::DATA_RESET;
      illegal_exc_o <= 1'b0;
      hw_breakpoint_request_n_exc_o <= 1'b0;
      bus_err_exc_o <= 1'b0;
      low_power_o <= 1'b0;
      stored_mask_o <= 3'h0;
      mask_q <= 3'h0;
      second_q <= 1'b0;
      lo_byte_q <= 8'h00;
    end else begin
      instr_valid_o <= 1'b0;
      illegal_exc_o <= 1'b0;
      hw_breakpoint_request_n_exc_o <= 1'b0;
      bus_err_exc_o <= 1'b0;
      if (end_ok && cyc_q == CYC_SW) begin
        if (port_8bit_i && !second_q) begin
          lo_byte_q <= data_in_i[15:8]; // RL6
          second_q <= 1'b1;
        end else begin
          instr_valid_o <= 1'b1; // RL6
          instr_word_o <= second_q ? {lo_byte_q, data_in_i[15:8]} : data_in_i;
          second_q <= 1'b0;
        end
      end
      if (end_bus_error_n) begin
        second_q <= 1'b0;
        illegal_exc_o <= (cyc_q == CYC_SW); // RL7
        hw_breakpoint_request_n_exc_o <= (cyc_q == CYC_HW); // RL9
        bus_err_exc_o <= (cyc_q == CYC_LP); // RL24
      end
      // size ack on a hardware breakpoint just drops it
      if (lp_done) begin
        mask_q <= interrupt_priority_mask_i; // RL13
        stored_mask_o <= interrupt_priority_mask_i;
      end
      low_power_o <= (state_d == ST_STOP); // RL17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_space_code: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL26
    !address_strobe_n_o |-> space_select_lines_o == cpu_space_pkg::SPACE_CPU)
    else $error("space code not cpu space during strobe");
  chk_hw_addr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL8
    (!address_strobe_n_o && cyc_q == CYC_HW) |-> addr_o == cpu_space_pkg::HW_BREAKPOINT_REQUEST_N_ADDR)
    else $error("hardware breakpoint address wrong");
  chk_lp_data: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL14
    data_oe_o |-> data_out_o[15:3] == 13'h0000 && addr_o == cpu_space_pkg::LP_STOP_ADDR)
    else $error("stop broadcast data or address wrong");
  chk_lp_fast: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL16
    $fell(address_strobe_n_o) && cyc_q == CYC_LP |=> ##[1:2] address_strobe_n_o)
    else $error("stop broadcast not internally terminated");
  chk_mon_bound: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL23
    state_q == ST_WAIT |-> mon_q < 6'h3F || state_d == ST_DONE)
    else $error("bus monitor exceeded its period");
  chk_halt_block: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL22
    (state_q == ST_HALT && !halt_n_s) |=> state_q != ST_ADDR)
    else $error("cycle started while halted");
  chk_sw_read: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL4
    (!address_strobe_n_o && cyc_q == CYC_SW) |-> read_write_o && addr_o[19:16] == 4'h0)
    else $error("software breakpoint cycle malformed");
  chk_hw_drop: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RL10
    (end_ok && cyc_q == CYC_HW) |=> !hw_breakpoint_request_n_exc_o)
    else $error("acked hardware breakpoint raised exception");

endmodule // cpu_space_bus
`default_nettype wire

// File: cpu_space_cycle_termination_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_space_cycle_termination_tb_top;
  localparam int TIMEOUT_CYCLES = 20000;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic sw_req = 1'b0;
  logic [2:0] sw_num = 3'h0;
  logic lp_stop = 1'b0;
  logic [2:0] interrupt_priority_mask = 3'h0;
  logic prefetch = 1'b0;
  logic instr_end = 1'b0;
  logic flush = 1'b0;
  logic port8 = 1'b0;
  logic [5:0] mon_limit = 6'h3F;
  logic [2:0] int_level = 3'h0;
  logic breakpoint_request_n_req_n = 1'b1;
  logic [2:0] mode = 3'h0;
  logic slow = 1'b0;
  logic halt_hold = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [1:0] ack_n;
  logic bus_error_n_n, halt_n, as_n, rw, oe, ivalid, ill, hwx, bex, lowp, as_prev;
  logic [15:0] din, dout, iword, cap_dout, cap_word;
  logic [23:0] addr, cap_addr;
  logic [2:0] fc, smask, cap_fc;
  logic cap_rw, cap_oe, cap_ds, ds_n;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_as = 0, n_valid = 0, n_ill = 0, n_hw = 0, n_bex = 0, low_len = 0;
  always #10 sys_clk = ~sys_clk;
  cpu_space_bus dut_u (.sys_clk_i(sys_clk), .rstn_i(rstn), .sw_breakpoint_request_n_req_i(sw_req),
    .sw_breakpoint_request_n_num_i(sw_num), .low_power_stop_instruction_i(lp_stop),
    .interrupt_priority_mask_i(interrupt_priority_mask), .prefetch_active_i(prefetch), .instr_end_i(instr_end),
    .pipe_flush_i(flush), .port_8bit_i(port8), .bus_mon_limit_i(mon_limit),
    .bus_granted_i(1'b1), .int_level_i(int_level), .breakpoint_request_n_i(breakpoint_request_n_req_n),
    .size_acknowledge_n_i(ack_n), .autovector_ack_n_i(1'b1), .bus_error_n_i(bus_error_n_n),
    .halt_n_i(halt_n), .data_in_i(din), .space_select_lines_o(fc), .addr_o(addr),
    .address_strobe_n_o(as_n), .data_strobe_n_o(ds_n), .read_write_o(rw), .data_out_o(dout),
    .data_oe_o(oe), .instr_valid_o(ivalid), .instr_word_o(iword), .illegal_exc_o(ill),
    .hw_breakpoint_request_n_exc_o(hwx), .bus_err_exc_o(bex), .low_power_o(lowp), .stored_mask_o(smask));
  cpu_space_partner partner_u (.sys_clk_i(sys_clk), .rstn_i(rstn), .mode_i(mode), .slow_i(slow),
    .port_8bit_i(port8), .halt_hold_i(halt_hold), .word_i(word), .space_select_lines_i(fc),
    .addr_i(addr), .address_strobe_n_i(as_n), .read_write_i(rw), .size_acknowledge_n_o(ack_n),
    .bus_error_n_o(bus_error_n_n), .halt_n_o(halt_n), .data_o(din));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    as_prev <= as_n;
    if (as_n === 1'b0) begin
      low_len <= (as_prev === 1'b1) ? 1 : low_len + 1;
    end
    if (as_n === 1'b0 && as_prev === 1'b1) begin
      n_as <= n_as + 1;
      cap_addr <= addr;
      cap_fc <= fc;
      cap_rw <= rw;
      cap_oe <= oe;
      cap_dout <= dout;
    end
    if (as_n === 1'b0 && ds_n === 1'b0) begin
      cap_ds <= 1'b0;
    end else if (as_n === 1'b0 && as_prev === 1'b1) begin
      cap_ds <= 1'b1;
    end
    if (ivalid === 1'b1) begin
      n_valid <= n_valid + 1;
      cap_word <= iword;
    end
    if (ill === 1'b1) n_ill <= n_ill + 1;
    if (hwx === 1'b1) n_hw <= n_hw + 1;
    if (bex === 1'b1) n_bex <= n_bex + 1;
    if (cyc == TIMEOUT_CYCLES) begin
      err_count++;
      $display("unexpected run length: expected below %0d cycles", TIMEOUT_CYCLES);
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // returns on the edge that samples a result pulse, so a request can drop there
  task automatic wait_done;
    for (int i = 0; i < 200 && ivalid !== 1'b1 && ill !== 1'b1 && hwx !== 1'b1 && bex !== 1'b1;
         i++) @(posedge sys_clk);
  endtask
  task automatic wait_as(input logic lvl);
    for (int i = 0; i < 200 && as_n !== lvl; i++) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sw_ack(input logic [2:0] num, input logic p8, input logic [15:0] w);
    int a;
    a = n_as;
    @(posedge sys_clk);
    sw_num <= num;
    port8 <= p8;
    word <= w;
    mode <= 3'h0;
    sw_req <= 1'b1;
    wait_done();
    sw_req <= 1'b0;
    tick(1);
    check("space", 24'(cap_fc), 24'(cpu_space_pkg::SPACE_CPU));
    check("data strobe", 24'(cap_ds), 24'h0);
    check("type", 24'(cap_addr[19:16]), 24'(cpu_space_pkg::TYPE_BREAKPOINT_REQUEST_N_ACK));
    check("number", 24'(cap_addr[4:2]), 24'(num));
    check("hw bit", 24'(cap_addr[1]), 24'h0);
    check("byte addr", 24'(cap_addr[0]), 24'(p8));
    check("reads", 24'(n_as - a), p8 ? 24'h2 : 24'h1);
    check("word", 24'(cap_word), 24'(w));
    $display("software breakpoint ack test done");
  endtask
  task automatic t_sw_fail(input logic [2:0] m, input logic [5:0] lim);
    int v, i;
    v = n_valid;
    i = n_ill;
    @(posedge sys_clk);
    mode <= m;
    mon_limit <= lim;
    slow <= 1'b1;
    sw_req <= 1'b1;
    wait_done();
    sw_req <= 1'b0;
    slow <= 1'b0;
    tick(1);
    check("illegal", 24'(n_ill - i), 24'h1);
    check("no word", 24'(n_valid - v), 24'h0);
    check("wait length", 24'(low_len <= int'(lim) + 6), 24'h1);
    $display("software breakpoint error test done");
  endtask
  task automatic t_hw(input logic [2:0] m, input logic pf, input logic fl, input int exp);
    int h, a;
    h = n_hw;
    a = n_as;
    @(posedge sys_clk);
    mode <= m;
    prefetch <= pf;
    breakpoint_request_n_req_n <= 1'b0;
    tick(2);
    breakpoint_request_n_req_n <= 1'b1;
    tick(8);
    check("early exception", 24'(n_hw - h), 24'h0);
    check("early cycle", 24'(n_as - a), 24'h0);
    if (fl) begin
      flush <= 1'b1;
      tick(1);
      flush <= 1'b0;
    end
    instr_end <= 1'b1;
    tick(1);
    instr_end <= 1'b0;
    prefetch <= 1'b0;
    tick(30);
    check("hw cycles", 24'(n_as - a), fl ? 24'h0 : 24'h1);
    if (!fl) begin
      check("hw addr", cap_addr, cpu_space_pkg::HW_BREAKPOINT_REQUEST_N_ADDR);
      check("hw space", 24'(cap_fc), 24'(cpu_space_pkg::SPACE_CPU));
    end
    check("hw exception", 24'(n_hw - h), 24'(exp));
    $display("hardware breakpoint test done");
  endtask
  task automatic t_stop;
    @(posedge sys_clk);
    interrupt_priority_mask <= 3'h5;
    int_level <= 3'h0;
    lp_stop <= 1'b1;
    wait_as(1'b0);
    @(posedge sys_clk);
    lp_stop <= 1'b0;
    for (int i = 0; i < 50 && lowp !== 1'b1; i++) @(negedge sys_clk);
    check("stop addr", cap_addr, cpu_space_pkg::LP_STOP_ADDR);
    check("stop type", 24'(cap_addr[19:16]), 24'(cpu_space_pkg::TYPE_LP_STOP));
    check("stop space", 24'(cap_fc), 24'(cpu_space_pkg::SPACE_CPU));
    check("stop write", 24'({cap_rw, cap_oe}), 24'h1);
    check("stop strobe", 24'(cap_ds), 24'h1);
    check("stop data", 24'(cap_dout), 24'h000005);
    check("stop length", 24'(low_len), 24'h2);
    check("stored mask", 24'(smask), 24'h5);
    int_level <= 3'h5;
    tick(8);
    check("still stopped", 24'(lowp), 24'h1);
    int_level <= 3'h6;
    for (int i = 0; i < 50 && lowp !== 1'b0; i++) @(negedge sys_clk);
    check("woken", 24'(lowp), 24'h0);
    $display("low power stop test done");
  endtask
  task automatic t_halt;
    int a, v;
    a = n_as;
    v = n_valid;
    @(posedge sys_clk);
    mode <= 3'h2;
    halt_hold <= 1'b1;
    sw_req <= 1'b1;
    wait_done();
    sw_req <= 1'b0;
    mode <= 3'h0;
    tick(1);
    check("halt end", 24'(n_valid - v), 24'h1);
    tick(2);
    sw_req <= 1'b1;
    tick(20);
    check("held off", 24'(n_as - a), 24'h1);
    halt_hold <= 1'b0;
    wait_done();
    sw_req <= 1'b0;
    tick(1);
    check("resumed", 24'(n_as - a), 24'h2);
    $display("halt test done");
  endtask
  task automatic t_retry;
    int a, v, i;
    a = n_as;
    v = n_valid;
    i = n_ill;
    @(posedge sys_clk);
    mode <= 3'h3;
    halt_hold <= 1'b1;
    sw_req <= 1'b1;
    wait_as(1'b0);
    wait_as(1'b1);
    tick(20);
    check("retry quiet", 24'(n_valid - v + n_ill - i), 24'h0);
    check("one try", 24'(n_as - a), 24'h1);
    mode <= 3'h0;
    halt_hold <= 1'b0;
    wait_done();
    sw_req <= 1'b0;
    tick(1);
    check("rerun", 24'(n_as - a), 24'h2);
    check("rerun word", 24'(n_valid - v), 24'h1);
    $display("retry test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    rstn <= 1'b1;
    tick(6);
    t_sw_ack(3'h2, 1'b1, 16'hA55A);
    t_sw_ack(3'h5, 1'b0, 16'h4E71);
    t_sw_fail(3'h1, 6'h3F);
    t_sw_fail(3'h4, 6'h08);
    t_hw(3'h1, 1'b0, 1'b0, 1);
    t_hw(3'h0, 1'b0, 1'b0, 0);
    t_hw(3'h1, 1'b1, 1'b1, 0);
    t_hw(3'h1, 1'b1, 1'b0, 1);
    t_stop();
    t_halt();
    t_retry();
    print_verdict();
  end
endmodule // cpu_space_cycle_termination_tb_top
`default_nettype wire

// File: cpu_space_partner.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_space_partner (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // scenario control: 0 ack, 1 bus error, 2 halt and ack, 3 retry, 4 silent
  input wire logic [2:0] mode_i,
  input wire logic slow_i,
  input wire logic port_8bit_i,
  input wire logic halt_hold_i,
  input wire logic [15:0] word_i,
  // bus pins
  input wire logic [2:0] space_select_lines_i,
  input wire logic [23:0] addr_i,
  input wire logic address_strobe_n_i,
  input wire logic read_write_i,
  output logic [1:0] size_acknowledge_n_o,
  output logic bus_error_n_o,
  output logic halt_n_o,
  output logic [15:0] data_o
);
  logic [5:0] wait_q;
  logic selected;
  logic answer_now;
  logic [7:0] byte_sel;
  // space select is only decoded while the strobe is low
  assign selected = !address_strobe_n_i && read_write_i && space_select_lines_i == 3'h7;
  assign answer_now = selected && wait_q == (slow_i ? 6'h06 : 6'h01);
  assign byte_sel = addr_i[0] ? word_i[7:0] : word_i[15:8];
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 6'h00;
      size_acknowledge_n_o <= 2'h3;
      bus_error_n_o <= 1'b1;
      halt_n_o <= 1'b1;
      data_o <= 16'hFFFF;
    end else if (selected) begin
      wait_q <= wait_q + 6'h01;
      if (answer_now) begin
        data_o <= port_8bit_i ? {byte_sel, ~byte_sel} : word_i;
        size_acknowledge_n_o <= (mode_i == 3'h0 || mode_i == 3'h2) ?
                                (port_8bit_i ? 2'h2 : 2'h0) : 2'h3;
        bus_error_n_o <= !(mode_i == 3'h1 || mode_i == 3'h3);
        halt_n_o <= !(mode_i == 3'h2 || mode_i == 3'h3);
      end
    end else begin
      wait_q <= 6'h00;
      size_acknowledge_n_o <= 2'h3;
      bus_error_n_o <= 1'b1;
      // released data bus inverts its last word each cycle
      data_o <= ~data_o;
      if (!halt_hold_i) begin
        halt_n_o <= 1'b1;
      end
    end
  end
endmodule // cpu_space_partner
`default_nettype wire

// File: cpu_space_pkg.sv
`default_nettype none
package cpu_space_pkg;

  // address space codes
  localparam logic [2:0] SPACE_CPU = 3'h7;
  localparam logic [2:0] SPACE_DEFAULT = 3'h5;

  // cpu space access types on address bits 19:16
  localparam logic [3:0] TYPE_BREAKPOINT_REQUEST_N_ACK = 4'h0;
  localparam logic [3:0] TYPE_LP_STOP = 4'h3;
  localparam logic [3:0] TYPE_INT_ACK = 4'hF;

  // field positions inside the address bus
  localparam int TYPE_LSB = 16;
  localparam int BREAKPOINT_REQUEST_N_NUM_LSB = 2;
  localparam int BREAKPOINT_REQUEST_N_HW_BIT = 1;

  // fixed addresses
  localparam logic [23:0] HW_BREAKPOINT_REQUEST_N_ADDR = 24'h00001E;
  localparam logic [23:0] LP_STOP_ADDR = 24'h03FFFE;
  localparam logic [2:0] HW_BREAKPOINT_REQUEST_N_NUM = 3'h7;

  // bus monitor timing
  localparam int BUS_MON_MAX_CYCLES = 64;
  localparam logic [5:0] BUS_MON_RESET = 6'h3F;

  // idle levels
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

endpackage

`default_nettype wire

// File: sync3.sv
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // pin side
  input wire logic [WIDTH-1:0] async_i,
  // synchronised side
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  // a change is accepted only once stages two and three agree
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
    end
  end

  assign sync_o = out_q;

endmodule // sync3
`default_nettype wire
